// [design/sdw_dac_if.sv]
// Behaviour
// - serial clock and data count only while chip select is low
// - strobe low copies input register into output register
// - strobe held low updates output at chip select rise after write
// - output code is straight unsigned binary
// - data field holds 8, 10 or 12 bits per resolution
// - gain bit one is unity gain, zero is doubled gain
// - gain defaults to doubled before any write
// - output stays shut down after power-up until write and strobe low
// - held in reset while supply low; leaves on next write loaded by strobe low
// - shutdown by command bit zero or by shutdown pin
// - serial interface keeps accepting writes during shutdown
// - shutdown switches pin from amplifier to resistive load
// - supply monitor off in pin shutdown, on in command shutdown
// - shutdown ends once written active bit and pin high both hold
// - link works in clock mode 0,0 or 1,1
// - data sampled on each of the first sixteen serial clock rising edges of a frame
// - receive only: no serial output, no readback
// - each command is exactly sixteen bits
// - word: enable, don't care, gain, active, data left aligned
// - command discarded when top bit is not zero
// - clocks past sixteen ignored; fewer than sixteen rejected
// - chip select rise after sixteen clocks latches word, earlier aborts
//
// serial dac write interface: link logic on the serial clock and chip select rise, output logic on ref_clk
// assumes nrst comes from the supply monitor and ref_clk runs free
`timescale 1ns/1ps
`include "sdw_defines.svh"
module sdw_dac_if
  import sdw_pkg::*;
#(
  parameter int RES_BITS = 12
) (
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  input  wire logic                sck,
  input  wire logic                cs_n,
  input  wire logic                sdi,
  input  wire logic                output_latch_strobe_n,
  input  wire logic                power_down_control_n,
  output logic [RES_BITS-1:0]      dac_code,
  output logic                     gain_select,
  output logic                     amp_enable,
  output logic                     load_enable,
  output logic                     por_monitor_enable,
  output logic                     word_pending
);
  // ====================================================
  // constants
  localparam logic [`SDW_CNT_BITS-1:0] WORD_LEN = `SDW_CNT_BITS'(`SDW_WORD_BITS);
  localparam int STROBE_CYC = `SDW_STROBE_CYC;
  localparam int DATA_LSB   = `SDW_DATA_MSB - RES_BITS + 1;

  // ====================================================
  // elaboration checks
  if (RES_BITS != 8 && RES_BITS != 10 && RES_BITS != 12) begin : g_bad_res
    $error("RES_BITS must be 8, 10 or 12");
  end

  // the bit counter must be able to hold the full word length
  if (`SDW_WORD_BITS >= (1 << `SDW_CNT_BITS)) begin : g_bad_cnt
    $error("bit counter too narrow for the command word");
  end

  // the strobe reaches ref_clk through two flops; a shorter low time may be missed
  if (STROBE_CYC < 3) begin : g_bad_strobe
    $error("strobe low time too short for the synchroniser");
  end

  // ====================================================
  // link domain: shift register on serial clock
  // no sdo port exists at all; the block is receive only
  logic [`SDW_WORD_BITS-1:0] shift;
  logic [`SDW_CNT_BITS-1:0]  bit_cnt;
  logic                      frame_full;
  logic                      frame_take;
  logic [`SDW_WORD_BITS-1:0] rx_word;
  logic                      rx_toggle;

  // sampling on rising sck serves both mode 0,0 and mode 1,1
  // counter clears asynchronously while cs_n is high
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= '0;
    end else if (!frame_full) begin
      bit_cnt <= bit_cnt + `SDW_CNT_BITS'(1);
    end
  end

  // counter stops at sixteen, so later clocks change nothing
  assign frame_full = (bit_cnt == WORD_LEN);

  // msb arrives first and ends up at the top of the word
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      shift <= `SDW_RST_WORD;
    end else if (!cs_n && !frame_full) begin
      shift <= {shift[`SDW_WORD_BITS-2:0], sdi};
    end
  end

  // ====================================================
  // link word capture
  // a set top bit throws the whole word away
  assign frame_take = frame_full && !shift[`SDW_BIT_ENABLE];

  // word captured at cs_n rise only when all sixteen bits arrived
  // sck may be stopped here, so the frame's own cs_n edge does the capture
  always_ff @(posedge cs_n or negedge nrst) begin
    if (!nrst) begin
      rx_word <= `SDW_RST_WORD;
    end else if (frame_take) begin
      rx_word <= shift;
    end
  end

  // one toggle per accepted word carries the news into ref_clk
  always_ff @(posedge cs_n or negedge nrst) begin
    if (!nrst) begin
      rx_toggle <= 1'b0;
    end else if (frame_take) begin
      rx_toggle <= ~rx_toggle;
    end
  end

  // ====================================================
  // crossings into ref_clk
  logic rx_toggle_s;
  logic strobe_n_s;
  logic pin_run_s;
  logic rx_toggle_d;

  sdw_sync #(.RST_VAL(1'b0)) u_sync_tog (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .async_in(rx_toggle),
    .sync_out(rx_toggle_s)
  );
  // the strobe idles high, so a reset value of one shows no false low
  sdw_sync #(.RST_VAL(1'b1)) u_sync_ld (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .async_in(output_latch_strobe_n),
    .sync_out(strobe_n_s)
  );
  // the pin reads as running during reset, so the supply monitor stays on
  sdw_sync #(.RST_VAL(1'b1)) u_sync_pd (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .async_in(power_down_control_n),
    .sync_out(pin_run_s)
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_toggle_d <= 1'b0;
    end else begin
      rx_toggle_d <= rx_toggle_s;
    end
  end

  logic new_word;
  // one pulse per accepted word, two flops after the toggle flips
  assign new_word = rx_toggle_s ^ rx_toggle_d;

  // ====================================================
  // input register, in the ref_clk domain
  // rx_word is stable well before the toggle arrives two flops later
  logic [RES_BITS-1:0] word_code;
  logic                word_gain;
  logic                word_active;
  logic [RES_BITS-1:0] in_code;
  logic                in_gain;
  logic                in_active;

  // left aligned data, one wire per code bit; low don't-care bits dropped
  for (genvar b = 0; b < RES_BITS; b++) begin : g_code
    assign word_code[b] = rx_word[DATA_LSB + b];
  end
  assign word_gain   = rx_word[`SDW_BIT_GAIN];
  assign word_active = rx_word[`SDW_BIT_ACTIVE];

  // held here so a later frame may shift in while the output waits for the strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      in_code <= '0;
    end else if (new_word) begin
      in_code <= word_code;
    end
  end

  // ====================================================
  // input settings
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      in_gain <= `SDW_RST_GAIN;
    end else if (new_word) begin
      in_gain <= word_gain;
    end
  end

  // a cleared active bit is a software shutdown request
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      in_active <= `SDW_RST_ACTIVE;
    end else if (new_word) begin
      in_active <= word_active;
    end
  end

  // word waiting since power-up; the output stays off until then
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      word_pending <= 1'b0;
    end else if (new_word) begin
      word_pending <= 1'b1;
    end
  end

  // ====================================================
  // output register transfer
  // level sensitive: strobe held low follows each new word, so a tied-low
  // strobe updates right after the cs_n rise that ends a write
  logic out_load;
  logic out_valid;
  logic out_active;

  assign out_load = !strobe_n_s && word_pending;

  // the code, gain and active bit all move on the same edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dac_code <= '0;
    end else if (out_load) begin
      dac_code <= in_code;
    end
  end

  // ====================================================
  // output settings
  // gain resets to the doubled setting
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gain_select <= `SDW_RST_GAIN;
    end else if (out_load) begin
      gain_select <= in_gain;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_active <= `SDW_RST_ACTIVE;
    end else if (out_load) begin
      out_active <= in_active;
    end
  end

  // marks the first transfer since reset; the mode machine leaves POR on it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
    end else if (out_load) begin
      out_valid <= 1'b1;
    end
  end

  // ====================================================
  // output stage mode
  // the serial path above runs in every mode, so writes wake it
  sdw_mode_t mode;
  sdw_mode_t next_mode;
  logic      run_req;

  // both the written active bit and the pin must allow running
  assign run_req = out_active && pin_run_s;

  always_comb begin
    next_mode = mode;
    case (mode)
      SDW_MODE_POR: begin
        if (out_valid) begin
          next_mode = SDW_MODE_POWER_DOWN_CONTROL;
        end
      end
      SDW_MODE_ACTIVE: begin
        if (!run_req) begin
          next_mode = SDW_MODE_POWER_DOWN_CONTROL;
        end
      end
      SDW_MODE_POWER_DOWN_CONTROL: begin
        if (run_req) begin
          next_mode = SDW_MODE_ACTIVE;
        end
      end
      default: begin
        next_mode = SDW_MODE_POR;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode <= SDW_MODE_POR;
    end else begin
      mode <= next_mode;
    end
  end

  logic next_active;
  assign next_active = (next_mode == SDW_MODE_ACTIVE);

  // ====================================================
  // output pins
  // amplifier off and resistive load on in every non-active mode
  // registered so the analog switches never see a decode glitch
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      amp_enable <= 1'b0;
    end else begin
      amp_enable <= next_active;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      load_enable <= 1'b1;
    end else begin
      load_enable <= !next_active;
    end
  end

  // pin shutdown drops the monitor, command shutdown keeps it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      por_monitor_enable <= 1'b1;
    end else begin
      por_monitor_enable <= pin_run_s;
    end
  end
endmodule // sdw_dac_if

// [design/sdw_defines.svh]
// constants for the serial dac write interface: word layout, reset values, timing
// assumes inclusion by bare name from the design files
`ifndef SDW_DEFINES_SVH
`define SDW_DEFINES_SVH
// ====================================================
// command word layout
`define SDW_WORD_BITS      16
`define SDW_BIT_ENABLE     15
`define SDW_BIT_GAIN       13
`define SDW_BIT_ACTIVE     12
`define SDW_DATA_MSB       11
`define SDW_CNT_BITS       5
// ====================================================
// reset values
`define SDW_RST_GAIN       1'b0
`define SDW_RST_ACTIVE     1'b0
`define SDW_RST_WORD       16'h0000
// ====================================================
// timing: output latch strobe shortest low time, in ns
`define SDW_STROBE_MIN_NS  100
`define SDW_CLK_NS         10
`define SDW_STROBE_CYC     ((`SDW_STROBE_MIN_NS + `SDW_CLK_NS - 1) / `SDW_CLK_NS)
`endif

// [design/sdw_pkg.sv]
// types shared by the serial dac write interface
// assumes the defines header is available
package sdw_pkg;
  // ====================================================
  // output stage mode
  typedef enum logic [1:0] {
    SDW_MODE_POR    = 2'b00,
    SDW_MODE_ACTIVE = 2'b01,
    SDW_MODE_POWER_DOWN_CONTROL   = 2'b10
  } sdw_mode_t;
endpackage

// [design/sdw_sync.sv]
// two flip-flop synchroniser for single-bit levels
// assumes the input is a level that is stable for several destination clocks
`timescale 1ns/1ps
module sdw_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // sdw_sync

// [test/sdw_dac_if_bench.sv]
// testbench for the serial dac write interface, 12 bit variant
// assumes the host model drives the link; pins driven on ref_clk falls
`timescale 1ns/1ps
module sdw_dac_if_bench;
  logic        ref_clk  = 1'b0;
  logic        nrst     = 1'b0;
  logic        strobe_n = 1'b1;
  logic        pin_n    = 1'b1;
  wire logic   sck, cs_n, sdi;
  logic [11:0] dac_code;
  logic        gain_select, amp_enable, load_enable, por_monitor_enable, word_pending;
  int          errors   = 0;
  int          n_tests  = 0;
  int          cycles   = 0;

  sdw_dac_if #(.RES_BITS(12)) uut (.ref_clk, .nrst, .sck, .cs_n, .sdi,
    .output_latch_strobe_n(strobe_n), .power_down_control_n(pin_n), .dac_code,
    .gain_select, .amp_enable, .load_enable, .por_monitor_enable, .word_pending);
  sdw_host_model host (.sck, .cs_n, .sdi);

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // ====================================================
  // checks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // f holds gain, amp, supply monitor, word flag
  task automatic outs(input logic [11:0] c, input logic [3:0] f);
    chk({4'h0, dac_code}, {4'h0, c});
    chk({12'h000, gain_select, amp_enable, por_monitor_enable, word_pending}, {12'h000, f});
    chk({15'h0000, load_enable}, {15'h0000, ~f[2]});
  endtask
  task complete_run;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // run needs about 1700 cycles; ceiling leaves ample margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end
  // ====================================================
  // scenarios
  initial begin
    wt(16);
    nrst = 1'b1;
    wt(2);
    outs(12'h000, 4'b0010);
    host.send(16'h3abc, 16, 1'b0);
    wt(12);
    outs(12'h000, 4'b0011);
    strobe_n = 1'b0;
    wt(15);
    strobe_n = 1'b1;
    wt(4);
    outs(12'habc, 4'b1111);
    strobe_n = 1'b0;
    host.send(16'h0123, 16, 1'b1);
    wt(12);
    outs(12'h123, 4'b0011);
    host.send(16'h9fff, 16, 1'b0);
    host.send(16'h3555, 15, 1'b1);
    wt(12);
    outs(12'h123, 4'b0011);
    host.send(16'h3456, 18, 1'b0);
    wt(12);
    outs(12'h456, 4'b1111);
    pin_n = 1'b0;
    wt(10);
    outs(12'h456, 4'b1001);
    host.send(16'h1777, 16, 1'b1);
    wt(12);
    outs(12'h777, 4'b0001);
    pin_n = 1'b1;
    wt(10);
    outs(12'h777, 4'b0111);
    nrst = 1'b0;
    wt(3);
    outs(12'h000, 4'b0010);
    nrst = 1'b1;
    wt(10);
    outs(12'h000, 4'b0010);
    host.send(16'h3001, 16, 1'b0);
    wt(12);
    outs(12'h001, 4'b1111);
    complete_run();
  end
endmodule // sdw_dac_if_bench

// [test/sdw_dac_if_monitor.sv]
// checker for the serial dac write interface output stage
// assumes pins are held for many ref_clk cycles between changes
`timescale 1ns/1ps
module sdw_dac_if_mon #(
  parameter int RES_BITS = 12
) (
  input wire logic                ref_clk,
  input wire logic                nrst,
  input wire logic                output_latch_strobe_n,
  input wire logic                power_down_control_n,
  input wire logic [RES_BITS-1:0] dac_code,
  input wire logic                gain_select,
  input wire logic                amp_enable,
  input wire logic                load_enable,
  input wire logic                por_monitor_enable,
  input wire logic                word_pending
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ====================================================
  // output stage
  AST_LOAD_INV:
  assert property (load_enable != amp_enable) else $error("load and amplifier both on or off");
  AST_PIN_POWER_DOWN_CONTROL:
  assert property (!power_down_control_n [*6] |-> !amp_enable && !por_monitor_enable)
    else $error("pin shutdown ignored");
  AST_POR_ON:
  assert property (power_down_control_n [*6] |-> por_monitor_enable)
    else $error("supply monitor off with pin high");
  AST_NO_WORD:
  assert property (!word_pending |-> !amp_enable && !gain_select && dac_code == '0)
    else $error("output changed before any write");
  AST_AMP_WORD:
  assert property (amp_enable |-> word_pending) else $error("amplifier on without a word");
  AST_AMP_RISE:
  assert property ($rose(amp_enable) |-> $past(power_down_control_n, 2))
    else $error("amplifier on while pin low");
  // slow strobe sync: six cycles high leaves room for the two flops
  AST_STROBE_HOLD:
  assert property (output_latch_strobe_n [*6] |-> $stable(dac_code) && $stable(gain_select))
    else $error("output moved with strobe high");
  AST_PENDING_HOLD:
  assert property (word_pending |=> word_pending) else $error("word flag dropped");
endmodule // sdw_dac_if_mon
bind sdw_dac_if sdw_dac_if_mon #(.RES_BITS(RES_BITS)) mon (.ref_clk, .nrst,
  .output_latch_strobe_n, .power_down_control_n, .dac_code, .gain_select, .amp_enable,
  .load_enable, .por_monitor_enable, .word_pending);

// [test/sdw_host_model.sv]
// serial host model: writes command words over chip select, clock and data
// assumes the caller spaces calls; sck runs only inside frames
`timescale 1ns/1ps
module sdw_host_model (
  output logic sck  = 1'b0,
  output logic cs_n = 1'b1,
  output logic sdi  = 1'b0
);
  // ====================================================
  // one frame of n clocks, mode 0,0 or 1,1 by cpol
  task automatic send(input logic [15:0] w, input int n, input logic cpol);
    sck = cpol;
    #40 cs_n = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      sdi = w[15 - (i % 16)];
      #62 sck = 1'b1;
      #63;
    end
    sck = cpol;
    #20 cs_n = 1'b1;
    // released line shows no stale bit
    sdi = ~sdi;
    #100;
  endtask
endmodule // sdw_host_model
